// File: hdl/spi_queue_pkg.sv
// constants, register map and state type for the spi queue controller
package spi_queue_pkg;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int MODE_BIT = 29;
  localparam int PHASE_BIT = 21;
  localparam int ORDER_BIT = 20;
  localparam int TXCLR_BIT = 18;
  localparam int RXCLR_BIT = 17;
  localparam int MASK_BIT = 16;
  localparam int SEL_BIT = 16;
  localparam int IE_LSB = 8;
  localparam int FLAG_LSB = 8;
  localparam int TXTH_LSB = 4;
  localparam int RXTH_LSB = 0;
  localparam logic [31:0] CFG_WMASK = 32'h2030_FFFF;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam int F_SEL_FALL = 7;
  localparam int F_SEL_RISE = 6;
  localparam int F_TX_UNDER = 5;
  localparam int F_TX_EMPTY = 4;
  localparam int F_TX_READY = 3;
  localparam int F_RX_OVF = 2;
  localparam int F_RX_FULL = 1;
  localparam int F_RX_READY = 0;
  localparam logic [7:0] IDLE_FILL = 8'hFF;
  localparam logic [3:0] LVL_EMPTY = 4'h0;
  localparam logic [3:0] QUEUE_DEPTH = 4'hF;
  localparam int SCK_HALF_CYC = 4;
  typedef enum logic {M_IDLE, M_RUN} master_state_t;
endpackage

// File: hdl/spi_queue_ctrl.sv
// spi byte engine with transmit and receive queues behind an ahb-lite slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
module spi_queue_ctrl #(
  parameter int SCK_HALF = spi_queue_pkg::SCK_HALF_CYC,
  parameter logic [3:0] DEPTH = spi_queue_pkg::QUEUE_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sck_in,
  input wire logic sel_in,
  input wire logic serial_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sel_out,
  output logic sel_oe,
  output logic serial_out,
  output logic serial_oe,
  output logic irq
);
  import spi_queue_pkg::*;

  logic [1:0] sck_sy_ff, sel_sy_ff, sin_sy_ff;
  logic sck_s, sel_s, sin_s, sck_d_ff;
  logic [31:0] cfg_ff, hrdata_ff, nxt_hrdata;
  logic [7:0] flags_ff, flag_set, dph_ofs_ff;
  logic sel_ctrl_ff, sel_out_ff, sel_mon_d_ff, irq_ff, oe_ff, serial_oe_ff, dph_wr_ff;
  logic master, phase, msb_first;
  logic [3:0] tx_thr, rx_thr;
  logic accept, wr_cfg, wr_stat, wr_dat, tx_clr, rx_clr;
  logic [7:0] tx_mem [16];
  logic [7:0] rx_mem [16];
  logic [3:0] tx_wr_ff, tx_rd_ff, tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] rx_wr_ff, rx_rd_ff, rx_cnt_ff, nxt_rx_cnt;
  logic tx_push, tx_pop, tx_avail, rx_push, rx_pop, rx_room;
  master_state_t m_state_ff;
  logic [7:0] m_div_ff;
  logic [3:0] m_edges_ff;
  logic m_sck_ff, m_tick, m_start;
  logic rise_ev, fall_ev, sample_ev, shift_ev, shift_now, load_ev, byte_done;
  logic sel_mon, sel_rise_ev, sel_fall_ev, underrun;
  logic [7:0] tx_sh_ff, rx_sh_ff, ld_byte, rx_byte;
  logic [2:0] bit_cnt_ff;

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // pin synchronisers; only the second stage is read
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_sy_ff <= 2'h0;
      sel_sy_ff <= 2'h0;
      sin_sy_ff <= 2'h0;
      sck_d_ff <= 1'b0;
    end else begin
      sck_sy_ff <= {sck_sy_ff[0], sck_in};
      sel_sy_ff <= {sel_sy_ff[0], sel_in};
      sin_sy_ff <= {sin_sy_ff[0], serial_in};
      sck_d_ff <= sck_sy_ff[1];
    end
  end
  assign sck_s = sck_sy_ff[1];
  assign sel_s = sel_sy_ff[1];
  assign sin_s = sin_sy_ff[1];

  assign master = cfg_ff[MODE_BIT];
  assign phase = cfg_ff[PHASE_BIT];
  assign msb_first = cfg_ff[ORDER_BIT];
  assign tx_thr = cfg_ff[TXTH_LSB +: 4];
  assign rx_thr = cfg_ff[RXTH_LSB +: 4];

  // ahb-lite: zero wait, read data captured at the address phase
  assign accept = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dph_wr_ff <= 1'b0;
      dph_ofs_ff <= 8'h00;
    end else begin
      dph_wr_ff <= accept && hwrite;
      if (accept) begin
        dph_ofs_ff <= haddr[7:0];
      end
    end
  end
  assign wr_cfg = dph_wr_ff && (dph_ofs_ff == CFG_OFS);
  assign wr_stat = dph_wr_ff && (dph_ofs_ff == STAT_OFS);
  assign wr_dat = dph_wr_ff && (dph_ofs_ff == DATA_OFS);
  assign tx_clr = wr_cfg && !hwdata[MASK_BIT] && hwdata[TXCLR_BIT];
  assign rx_clr = wr_cfg && !hwdata[MASK_BIT] && hwdata[RXCLR_BIT];

  always_comb begin
    case (haddr[7:0])
      CFG_OFS: nxt_hrdata = cfg_ff;
      STAT_OFS: nxt_hrdata = {15'h0000, master ? sel_ctrl_ff : sel_s, flags_ff, tx_cnt_ff, rx_cnt_ff};
      DATA_OFS: nxt_hrdata = {24'h000000, (rx_cnt_ff != LVL_EMPTY) ? rx_mem[rx_rd_ff] : 8'h00};
      default: nxt_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata_ff <= nxt_hrdata;
    end
  end
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1 | sys_rst;
  assign hresp = 1'b0 & sys_rst;

  // configuration; clear and mask bits are not stored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= CFG_RST;
    end else if (wr_cfg) begin
      if (hwdata[MASK_BIT]) begin
        cfg_ff[15:0] <= hwdata[15:0];
      end else begin
        cfg_ff <= hwdata & CFG_WMASK;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_ctrl_ff <= 1'b0;
    end else if (wr_stat && master) begin
      sel_ctrl_ff <= hwdata[SEL_BIT];
    end
  end

  // master clock engine: sixteen half periods per byte
  assign m_tick = (m_state_ff == M_RUN) && (m_div_ff == 8'(SCK_HALF - 1));
  assign m_start = (m_state_ff == M_IDLE) && master && sel_out_ff && tx_avail && !tx_clr;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_state_ff <= M_IDLE;
      m_div_ff <= 8'h00;
      m_edges_ff <= 4'h0;
      m_sck_ff <= 1'b0;
    end else if (tx_clr || !master) begin
      m_state_ff <= M_IDLE;
      m_div_ff <= 8'h00;
      m_edges_ff <= 4'h0;
      m_sck_ff <= 1'b0;
    end else begin
      case (m_state_ff)
        M_IDLE: begin
          if (m_start) begin
            m_state_ff <= M_RUN;
            m_div_ff <= 8'h00;
            m_edges_ff <= 4'h0;
          end
        end
        M_RUN: begin
          if (m_tick) begin
            m_div_ff <= 8'h00;
            m_sck_ff <= !m_sck_ff;
            m_edges_ff <= m_edges_ff + 4'h1;
            if (m_edges_ff == 4'hF) begin
              m_state_ff <= M_IDLE;
            end
          end else begin
            m_div_ff <= m_div_ff + 8'h01;
          end
        end
        default: m_state_ff <= M_IDLE;
      endcase
    end
  end

  // select follows software only between bytes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_out_ff <= 1'b0;
    end else if (!master) begin
      sel_out_ff <= 1'b0;
    end else if (m_state_ff == M_IDLE && !m_start) begin
      sel_out_ff <= sel_ctrl_ff;
    end
  end

  // clock edges; in slave mode the select gates the clock
  assign rise_ev = master ? (m_tick && !m_sck_ff) : (sel_s && sck_s && !sck_d_ff);
  assign fall_ev = master ? (m_tick && m_sck_ff) : (sel_s && !sck_s && sck_d_ff);
  assign sample_ev = phase ? fall_ev : rise_ev;
  assign shift_ev = phase ? rise_ev : fall_ev;
  assign sel_mon = master ? sel_out_ff : sel_s;
  assign sel_rise_ev = sel_mon && !sel_mon_d_ff;
  assign sel_fall_ev = !sel_mon && sel_mon_d_ff;
  assign load_ev = master ? m_start : ((shift_ev && bit_cnt_ff == 3'h0) || (sel_rise_ev && !phase));
  assign shift_now = shift_ev && (bit_cnt_ff != 3'h0) && !load_ev;
  assign tx_avail = (tx_cnt_ff != LVL_EMPTY) && (tx_thr != 4'h0);
  assign tx_pop = load_ev && tx_avail;
  assign underrun = load_ev && !master && !tx_avail;
  assign ld_byte = tx_avail ? tx_mem[tx_rd_ff] : IDLE_FILL;
  assign rx_byte = msb_first ? {rx_sh_ff[6:0], sin_s} : {sin_s, rx_sh_ff[7:1]};
  assign byte_done = sample_ev && (bit_cnt_ff == 3'h7);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_mon_d_ff <= 1'b0;
    end else begin
      sel_mon_d_ff <= sel_mon;
    end
  end

  // shifters; transmit bit always leaves from bit 7
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sh_ff <= IDLE_FILL;
      rx_sh_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else begin
      if (tx_clr) begin
        tx_sh_ff <= IDLE_FILL;
      end else if (load_ev) begin
        tx_sh_ff <= msb_first ? ld_byte : bit_rev(ld_byte);
      end else if (shift_now) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
      end
      if (rx_clr) begin
        rx_sh_ff <= 8'h00;
      end else if (sample_ev) begin
        rx_sh_ff <= rx_byte;
      end
      if (tx_clr || rx_clr || (!master && sel_rise_ev)) begin
        bit_cnt_ff <= 3'h0;
      end else if (sample_ev) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // queues: sixteen slots, at most DEPTH held
  assign tx_push = wr_dat && (tx_thr != 4'h0) && (tx_cnt_ff != DEPTH);
  assign rx_room = rx_cnt_ff != DEPTH;
  assign rx_push = byte_done && (rx_thr != 4'h0) && rx_room && !rx_clr;
  assign rx_pop = accept && !hwrite && (haddr[7:0] == DATA_OFS) && (rx_cnt_ff != LVL_EMPTY);

  always_comb begin
    case ({tx_push, tx_pop})
      2'b10: nxt_tx_cnt = tx_cnt_ff + 4'h1;
      2'b01: nxt_tx_cnt = tx_cnt_ff - 4'h1;
      default: nxt_tx_cnt = tx_cnt_ff;
    endcase
    if (tx_clr) begin
      nxt_tx_cnt = LVL_EMPTY;
    end
    case ({rx_push, rx_pop})
      2'b10: nxt_rx_cnt = rx_cnt_ff + 4'h1;
      2'b01: nxt_rx_cnt = rx_cnt_ff - 4'h1;
      default: nxt_rx_cnt = rx_cnt_ff;
    endcase
    if (rx_clr) begin
      nxt_rx_cnt = LVL_EMPTY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_ff] <= hwdata[7:0];
    end
    if (rx_push) begin
      rx_mem[rx_wr_ff] <= rx_byte;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wr_ff <= 4'h0;
      tx_rd_ff <= 4'h0;
      tx_cnt_ff <= LVL_EMPTY;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      if (tx_clr) begin
        tx_wr_ff <= 4'h0;
        tx_rd_ff <= 4'h0;
      end else begin
        if (tx_push) begin
          tx_wr_ff <= tx_wr_ff + 4'h1;
        end
        if (tx_pop) begin
          tx_rd_ff <= tx_rd_ff + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wr_ff <= 4'h0;
      rx_rd_ff <= 4'h0;
      rx_cnt_ff <= LVL_EMPTY;
    end else begin
      rx_cnt_ff <= nxt_rx_cnt;
      if (rx_clr) begin
        rx_wr_ff <= 4'h0;
        rx_rd_ff <= 4'h0;
      end else begin
        if (rx_push) begin
          rx_wr_ff <= rx_wr_ff + 4'h1;
        end
        if (rx_pop) begin
          rx_rd_ff <= rx_rd_ff + 4'h1;
        end
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_comb begin
    flag_set = 8'h00;
    flag_set[F_SEL_FALL] = sel_fall_ev;
    flag_set[F_SEL_RISE] = sel_rise_ev;
    flag_set[F_TX_UNDER] = underrun;
    flag_set[F_TX_EMPTY] = (tx_cnt_ff != LVL_EMPTY) && (nxt_tx_cnt == LVL_EMPTY);
    flag_set[F_TX_READY] = (tx_thr != 4'h0) && (nxt_tx_cnt == tx_thr) && (tx_cnt_ff != tx_thr);
    flag_set[F_RX_OVF] = byte_done && (rx_thr != 4'h0) && !rx_room;
    flag_set[F_RX_FULL] = (nxt_rx_cnt == 4'hF) && (rx_cnt_ff != 4'hF);
    flag_set[F_RX_READY] = (rx_thr != 4'h0) && (nxt_rx_cnt == rx_thr) && (rx_cnt_ff != rx_thr);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff <= FLAGS_RST;
      irq_ff <= 1'b0;
    end else begin
      flags_ff <= (wr_stat ? (flags_ff & hwdata[FLAG_LSB +: 8]) : flags_ff) | flag_set;
      irq_ff <= |(flags_ff & cfg_ff[IE_LSB +: 8]);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_ff <= 1'b0;
      serial_oe_ff <= 1'b0;
    end else begin
      oe_ff <= master;
      serial_oe_ff <= master || sel_s;
    end
  end
  assign sck_out = m_sck_ff;
  assign sck_oe = oe_ff;
  assign sel_out = sel_out_ff;
  assign sel_oe = oe_ff;
  assign serial_out = tx_sh_ff[7];
  assign serial_oe = serial_oe_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_byte_start;
    m_start;
  endsequence
  sequence s_running;
    (m_state_ff == M_RUN) [*8];
  endsequence

  a_sel_between_bytes: assert property (m_state_ff == M_RUN |=> $stable(sel_out_ff))
    else $error("select moved during a byte");
  a_sck_needs_sel: assert property (m_state_ff == M_RUN |-> sel_out_ff)
    else $error("clock running without select");
  a_byte_runs: assert property (s_byte_start |=> s_running)
    else $error("master byte cut short");
  a_tx_clear: assert property (tx_clr |=> tx_cnt_ff == 4'h0 && m_state_ff == M_IDLE)
    else $error("tx clear did not empty queue");
  a_rx_clear: assert property (rx_clr |=> rx_cnt_ff == 4'h0 && bit_cnt_ff == 3'h0)
    else $error("rx clear did not empty queue");
  a_mask_upper: assert property (wr_cfg && hwdata[MASK_BIT] |=> cfg_ff[31:16] == $past(cfg_ff[31:16]))
    else $error("masked write changed upper config");
  a_fall_flag: assert property (sel_fall_ev |=> flags_ff[F_SEL_FALL])
    else $error("select fall flag not set");
  a_rise_flag: assert property (sel_rise_ev |=> flags_ff[F_SEL_RISE])
    else $error("select rise flag not set");
  a_rx_overflow: assert property (byte_done && rx_thr != 4'h0 && rx_cnt_ff == DEPTH |=> flags_ff[F_RX_OVF])
    else $error("overflow flag not set");
  a_idle_fill: assert property (!master && load_ev && !tx_avail |=> tx_sh_ff == IDLE_FILL)
    else $error("slave did not load fill byte");
  a_irq_follow: assert property ((|(flags_ff & cfg_ff[IE_LSB +: 8])) |=> irq_ff)
    else $error("irq missing for enabled flag");
endmodule

// File: dv/spi_peer_model.sv
// spi peer: slave when the block is master, frame-driving master when the block is slave
module spi_peer_model (
  input wire logic sck_out,
  input wire logic sel_out,
  input wire logic serial_out,
  input wire logic serial_oe,
  input wire logic as_master,
  input wire logic phase,
  input wire logic msb_first,
  input wire logic [7:0] reply_byte,
  input wire logic [4:0] frame_len,
  input wire logic frame_go,
  output logic sck_in,
  output logic sel_in,
  output logic serial_in,
  output logic frame_busy,
  output logic [15:0] got_pair
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_sh, rx_sh, nbytes;
  int n;
  wire logic sck = as_master ? sck_in : sck_out;
  wire logic sel = as_master ? sel_in : sel_out;
  initial begin
    sck_in = 1'b0;
    sel_in = 1'b0;
    serial_in = 1'b1;
    frame_busy = 1'b0;
    got_pair = 16'h0000;
    n = 0;
    nbytes = 8'h00;
  end
  function automatic logic bit_at(input logic [7:0] b, input int i);
    return msb_first ? b[7 - i] : b[i];
  endfunction
  // each byte of a frame answers reply_byte plus its position
  task automatic drive_bit();
    if (n == 8) begin
      n = 0;
      nbytes++;
    end
    tx_sh = reply_byte + nbytes;
    serial_in = bit_at(tx_sh, n);
  endtask
  task automatic sample_bit();
    rx_sh[msb_first ? 7 - n : n] = serial_out & serial_oe;
    n++;
    if (n == 8) got_pair = {got_pair[7:0], rx_sh};
  endtask
  always @(posedge sel) begin
    n = 0;
    nbytes = 8'h00;
    if (!phase) drive_bit();
  end
  always @(posedge sck) if (sel) begin
    if (phase) drive_bit();
    else sample_bit();
  end
  always @(negedge sck) if (sel) begin
    if (phase) sample_bit();
    else drive_bit();
  end
  // a released data line must not keep showing its last bit
  always @(negedge sel) serial_in = ~serial_in;
  // link clock runs only inside a frame, 125 ns period
  always @(posedge frame_go) begin
    frame_busy = 1'b1;
    #40 sel_in = 1'b1;
    #300;
    repeat (8 * frame_len) begin
      #62.5 sck_in = 1'b1;
      #62.5 sck_in = 1'b0;
    end
    #300 sel_in = 1'b0;
    #300 frame_busy = 1'b0;
  end
endmodule

// File: dv/tb_spi_queue_ctrl.sv
// self-checking bench for the spi queue controller against its spi peer
module tb_spi_queue_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_queue_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic ref_clk, sys_rst, hsel, hwrite, hreadyout, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sck_in, sel_in, serial_in, sck_out, sel_out, serial_out, serial_oe;
  logic as_master, phase, msb_first, frame_go, frame_busy;
  logic [7:0] reply_byte;
  logic [4:0] frame_len;
  logic [15:0] got_pair;
  int err_total = 0;
  int total_checks = 0;
  int sck_rises = 0;
  spi_queue_ctrl u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .sck_in(sck_in), .sel_in(sel_in), .serial_in(serial_in), .sck_out(sck_out), .sck_oe(),
    .sel_out(sel_out), .sel_oe(), .serial_out(serial_out), .serial_oe(serial_oe), .irq(irq)
  );
  spi_peer_model u_peer (
    .sck_out(sck_out), .sel_out(sel_out), .serial_out(serial_out), .serial_oe(serial_oe), .as_master(as_master),
    .phase(phase), .msb_first(msb_first), .reply_byte(reply_byte), .frame_len(frame_len), .frame_go(frame_go),
    .sck_in(sck_in), .sel_in(sel_in), .serial_in(serial_in), .frame_busy(frame_busy), .got_pair(got_pair)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge sck_out) sck_rises++;
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      chk("hready wait", 32'h0, 32'h1);
      end_of_test();
    end
  endtask
  // one single word transfer; an idle cycle always precedes it
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, ofs};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ofs, d, x);
  endtask
  task automatic rc(input string what, input logic [7:0] ofs, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, ofs, 32'h0, x);
    chk(what, x & m, exp);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] x;
    for (int k = 0; k < 300; k++) begin
      bus(1'b0, STAT_OFS, 32'h0, x);
      if ((x & m) === v) return;
    end
    chk("status poll", x & m, v);
    end_of_test();
  endtask
  task automatic frame(input logic [4:0] len);
    frame_len <= len;
    frame_go <= 1'b1;
    @(posedge ref_clk);
    frame_go <= 1'b0;
    for (int k = 0; k < 2500 && (k < 2 || frame_busy === 1'b1); k++) @(posedge ref_clk);
    if (frame_busy !== 1'b0) begin
      chk("frame end", 32'h1, 32'h0);
      end_of_test();
    end
  endtask
  task automatic t_reset_map();
    rc("cfg reset", CFG_OFS, ALL, CFG_RST);
    rc("status reset", STAT_OFS, ALL, 32'h0);
    rc("unmapped", 8'h0C, ALL, 32'h0);
  endtask
  task automatic t_mask();
    wr(CFG_OFS, 32'h2030_00AB);
    rc("cfg full", CFG_OFS, ALL, 32'h2030_00AB);
    wr(CFG_OFS, 32'h0001_5A3C);
    rc("cfg masked", CFG_OFS, ALL, 32'h2030_5A3C);
    wr(CFG_OFS, ALL);
    rc("cfg masked ones", CFG_OFS, ALL, 32'h2030_FFFF);
    wr(CFG_OFS, 32'h0);
  endtask
  task automatic t_master();
    as_master <= 1'b0;
    phase <= 1'b0;
    msb_first <= 1'b1;
    reply_byte <= 8'hC5;
    wr(CFG_OFS, 32'h2010_1022);
    wr(DATA_OFS, 32'h3A);
    wr(DATA_OFS, 32'hA7);
    rc("tx ready", STAT_OFS, ALL, 32'h0000_0820);
    chk("sck idle", sck_rises, 0);
    wr(STAT_OFS, 32'h0001_0000);
    poll(32'hF, 32'h2);
    rc("master done", STAT_OFS, ALL, 32'h0001_5102);
    chk("irq on", irq, 1'b1);
    chk("peer bytes", got_pair, 16'h3AA7);
    rc("rx pop 1", DATA_OFS, ALL, 32'hC5);
    rc("rx pop 2", DATA_OFS, ALL, 32'hC6);
    chk("sck count", sck_rises, 16);
    wr(STAT_OFS, 32'h0);
    // select output drops one cycle after the write, its flag one cycle later
    repeat (2) @(posedge ref_clk);
    rc("select fall", STAT_OFS, ALL, 32'h0000_8000);
    chk("irq off", irq, 1'b0);
  endtask
  task automatic t_slave();
    as_master <= 1'b1;
    phase <= 1'b1;
    msb_first <= 1'b0;
    reply_byte <= 8'h96;
    wr(CFG_OFS, 32'h0020_0011);
    wr(STAT_OFS, 32'h0);
    frame(5'd1);
    chk("idle fill", got_pair[7:0], 8'hFF);
    rc("slave flags", STAT_OFS, ALL, 32'h0000_E101);
    rc("slave rx", DATA_OFS, ALL, 32'h96);
    wr(DATA_OFS, 32'h1E);
    frame(5'd1);
    chk("slave tx", got_pair[7:0], 8'h1E);
    rc("slave rx 2", DATA_OFS, ALL, 32'h96);
  endtask
  task automatic t_queue_edges();
    reply_byte <= 8'h40;
    wr(CFG_OFS, 32'h0020_001F);
    wr(STAT_OFS, 32'h0);
    frame(5'd16);
    rc("rx overflow", STAT_OFS, ALL, 32'h0000_E70F);
    rc("oldest byte", DATA_OFS, ALL, 32'h40);
    wr(CFG_OFS, 32'h0022_001F);
    rc("rx cleared", STAT_OFS, 32'hF, 32'h0);
    repeat (3) wr(DATA_OFS, 32'h11);
    rc("tx level", STAT_OFS, 32'hF0, 32'h30);
    wr(CFG_OFS, 32'h0024_001F);
    rc("tx cleared", STAT_OFS, 32'hF0, 32'h0);
    wr(CFG_OFS, 32'h0020_000F);
    wr(DATA_OFS, 32'h22);
    rc("tx disabled", STAT_OFS, 32'hF0, 32'h0);
  endtask
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    as_master = 1'b0;
    phase = 1'b0;
    msb_first = 1'b1;
    reply_byte = 8'h00;
    frame_len = 5'd0;
    frame_go = 1'b0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_map();
    t_mask();
    t_master();
    t_slave();
    t_queue_edges();
    end_of_test();
  end
endmodule
